//--- inc/vmt_pkg.sv
`include "vmt_regs.svh"

package vmt_pkg;

  typedef enum logic {
    VMT_IDLE,
    VMT_LOOK
  } vmt_state_t;

  typedef struct packed {
    logic [`VMT_EPN_W-1:0]  tag;
    logic [`VMT_SIZE_W-1:0] size;
    logic                   valid;
    logic [`VMT_PID_W-1:0]  entry_process_tag;
    logic [`VMT_EPN_W-1:0]  rpn;
  } vmt_entry_t;

  // page-number bits that take part in compare and relocation
  function automatic logic [`VMT_EPN_W-1:0] vmt_mask(input logic [`VMT_SIZE_W-1:0] size);
    vmt_mask = {`VMT_EPN_W{1'b1}} << {size, 1'b0};
  endfunction

  function automatic logic vmt_hit(input vmt_entry_t e,
                                   input logic [`VMT_EPN_W-1:0] effective_page_number,
                                   input logic [`VMT_PID_W-1:0] process_identifier_register);
    logic pid_ok;
    pid_ok  = (e.entry_process_tag == `VMT_TID_GLOBAL) || (e.entry_process_tag == process_identifier_register);
    vmt_hit = e.valid && pid_ok && (((e.tag ^ effective_page_number) & vmt_mask(e.size)) == '0);
  endfunction

  function automatic logic [`VMT_ADDR_W-1:0] vmt_phys(input vmt_entry_t e,
                                                     input logic [`VMT_ADDR_W-1:0] ea);
    logic [`VMT_EPN_W-1:0] m;
    m        = vmt_mask(e.size);
    vmt_phys = {(e.rpn & m) | (ea[`VMT_ADDR_W-1:`VMT_OFS_W] & ~m), ea[`VMT_OFS_W-1:0]};
  endfunction

endpackage

//--- inc/vmt_regs.svh
`ifndef VMT_REGS_SVH
`define VMT_REGS_SVH

// special-purpose register address of the process identifier
`define VMT_PID_SPR_ADDR  10'h3B1
`define VMT_SPR_ADDR_W    10
`define VMT_PID_W         8
`define VMT_PID_LSB       0
`define VMT_PID_RST       8'h00
`define VMT_TID_GLOBAL    8'h00

// smallest page is 1 KB: 10 offset bits, 22 page-number bits
`define VMT_OFS_W         10
`define VMT_EPN_W         22
`define VMT_SIZE_W        3
`define VMT_ADDR_W        32

`define VMT_UNIFIED_TRANSLATION_BUFFER_ENTRIES  64
`define VMT_INSTRUCTION_SHADOW_BUFFER_ENTRIES  4
`define VMT_DATA_SHADOW_BUFFER_ENTRIES  8

`define VMT_CHAN_INSN     0
`define VMT_CHAN_DATA     1
`define VMT_CHANS         2

`endif

//--- inc/vmt_shadow_if.sv
`timescale 1ns/10ps
`include "vmt_regs.svh"

interface vmt_shadow_if;
  logic [`VMT_ADDR_W-1:0] ea;
  logic [`VMT_PID_W-1:0]  process_identifier_register;
  logic                   hit;
  logic [`VMT_ADDR_W-1:0] pa;
  logic                   fill_en;
  vmt_pkg::vmt_entry_t    fill_ent;
  logic                   inval;

  modport ctl (output ea, output process_identifier_register, output fill_en, output fill_ent, output inval,
               input hit, input pa);
  modport shb (input ea, input process_identifier_register, input fill_en, input fill_ent, input inval,
               output hit, output pa);
endinterface

//--- testbench/vmt_core_model.sv
`timescale 1ns/10ps

module vmt_core_model (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        go,
  input wire logic [31:0] ea_in,
  input wire logic        ready,
  output logic            req,
  output logic [31:0]     ea
);
  // address line shows inverted value once released, never a stale copy
  always @(posedge core_clk) begin
    if (rst) begin
      req <= 1'b0;
      ea  <= 32'h0000_0000;
    end else if (req && ready) begin
      req <= 1'b0;
      ea  <= ~ea;
    end else if (go) begin
      req <= 1'b1;
      ea  <= ea_in;
    end
  end
endmodule

//--- testbench/vmt_translate_monitor.sv
`timescale 1ns/10ps
`include "vmt_regs.svh"

module vmt_translate_monitor (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       instruction_relocate_bit,
  input wire logic                       data_relocate_bit,
  input wire logic                       spr_wr_en,
  input wire logic                       spr_rd_en,
  input wire logic                       spr_priv,
  input wire logic [`VMT_SPR_ADDR_W-1:0] spr_addr,
  input wire logic [31:0]                spr_rdata,
  input wire logic                       spr_ack,
  input wire logic                       spr_fault,
  input wire logic                       fetch_req,
  input wire logic [`VMT_ADDR_W-1:0]     fetch_effective_address,
  input wire logic                       fetch_ready,
  input wire logic                       fetch_done,
  input wire logic                       fetch_miss,
  input wire logic [`VMT_ADDR_W-1:0]     fetch_pa,
  input wire logic                       data_req,
  input wire logic                       data_ready,
  input wire logic                       data_done,
  input wire logic                       data_miss,
  input wire logic [`VMT_ADDR_W-1:0]     data_pa,
  input wire logic [`VMT_ADDR_W-1:0]     data_effective_address
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [31:0] ea_ff;
  logic [31:0] nxt_ea;
  always_comb begin
    nxt_ea = ea_ff;
    if (fetch_req && fetch_ready) begin
      nxt_ea = fetch_effective_address;
    end
  end
  always_ff @(posedge core_clk) begin
    ea_ff <= nxt_ea;
  end

  sequence take_f; fetch_req && fetch_ready; endsequence
  sequence take_d; data_req && data_ready; endsequence
  sequence spr_hit; (spr_wr_en || spr_rd_en) && spr_addr == 10'h3B1; endsequence

  fetch_answer_a: assert property (take_f |-> ##[2:20] fetch_done)
    else $error("fetch request not answered");
  data_answer_a: assert property (take_d |-> ##[2:20] data_done)
    else $error("data request not answered");
  fetch_real_a: assert property (take_f ##0 !instruction_relocate_bit |->
    ##2 fetch_done && !fetch_miss && fetch_pa == $past(fetch_effective_address, 2))
    else $error("real mode fetch address altered");
  data_real_a: assert property (take_d ##0 !data_relocate_bit |->
    ##2 data_done && !data_miss && data_pa == $past(data_effective_address, 2))
    else $error("real mode data address altered");
  miss_pulse_a: assert property ((fetch_miss |-> fetch_done) and (data_miss |-> data_done))
    else $error("miss without done");
  miss_zero_a: assert property (fetch_done && fetch_miss |-> fetch_pa == 32'h0000_0000)
    else $error("miss returned nonzero address");
  offset_pass_a: assert property (fetch_done |-> fetch_pa[9:0] == ea_ff[9:0] || fetch_miss)
    else $error("page offset altered");
  spr_ack_a: assert property (spr_hit ##0 spr_priv |=> spr_ack && !spr_fault)
    else $error("privileged access not acknowledged");
  spr_fault_a: assert property (spr_hit ##0 !spr_priv |=> spr_fault && !spr_ack)
    else $error("unprivileged access not refused");
  spr_other_a: assert property ((spr_wr_en || spr_rd_en) && spr_addr != 10'h3B1
    |=> !spr_ack && !spr_fault)
    else $error("unmapped register answered");
  pid_width_a: assert property (spr_ack |-> spr_rdata[31:8] == 24'h00_0000)
    else $error("reserved identifier bits nonzero");
  fetch_busy_a: assert property (take_f |=> !fetch_ready)
    else $error("fetch channel still ready after taking a request");
  data_busy_a: assert property (take_d |=> !data_ready)
    else $error("data channel still ready after taking a request");
endmodule

bind vmt_translate vmt_translate_monitor u_mon (.core_clk, .rst, .instruction_relocate_bit,
  .data_relocate_bit, .spr_wr_en, .spr_rd_en, .spr_priv, .spr_addr, .spr_rdata, .spr_ack,
  .spr_fault, .fetch_req, .fetch_effective_address, .fetch_ready, .fetch_done, .fetch_miss,
  .fetch_pa, .data_req, .data_ready, .data_done, .data_miss, .data_pa,
  .data_effective_address);

//--- testbench/vmt_translate_tb.sv
`timescale 1ns/10ps
`include "vmt_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module vmt_translate_tb;
  logic core_clk = 0, rst = 1, ir = 0, dr = 0, wr = 0, rd = 0, priv = 0;
  logic [9:0] addr = 0;
  logic [31:0] wdata = 0, rdata, fpa, dpa, seed = 32'hDC3A, ea_f = 0, ea_d = 0;
  logic tw = 0, tvalid = 0, inval = 0, go_f = 0, go_d = 0;
  logic [5:0] tidx = 0;
  logic [21:0] ttag = 0, trpn = 0;
  logic [2:0] tsize = 0;
  logic [7:0] ttid = 0;
  logic ack, fault, freq, fready, fdone, fmiss, dreq, dready, ddone, dmiss;
  logic [31:0] fea, dea;
  logic [32:0] q_f[$], q_d[$], q_s[$];
  // oldest note taken once, so a mismatch report shows the same note that was compared
  logic [32:0] exp_f, exp_d, exp_s;
  int num_errors = 0, total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  vmt_translate u_dut (.core_clk, .rst, .instruction_relocate_bit(ir), .data_relocate_bit(dr),
    .spr_wr_en(wr), .spr_rd_en(rd), .spr_priv(priv), .spr_addr(addr), .spr_wdata(wdata),
    .spr_rdata(rdata), .spr_ack(ack), .spr_fault(fault), .tlb_wr_en(tw), .tlb_wr_index(tidx),
    .tlb_wr_tag(ttag), .tlb_wr_size(tsize), .tlb_wr_valid(tvalid), .tlb_wr_tid(ttid),
    .tlb_wr_rpn(trpn), .shadow_inval(inval), .fetch_req(freq), .fetch_effective_address(fea),
    .fetch_ready(fready), .fetch_done(fdone), .fetch_miss(fmiss), .fetch_pa(fpa),
    .data_req(dreq), .data_effective_address(dea), .data_ready(dready), .data_done(ddone),
    .data_miss(dmiss), .data_pa(dpa));
  vmt_core_model u_fetch (.core_clk, .rst, .go(go_f), .ea_in(ea_f), .ready(fready),
    .req(freq), .ea(fea));
  vmt_core_model u_data (.core_clk, .rst, .go(go_d), .ea_in(ea_d), .ready(dready),
    .req(dreq), .ea(dea));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] exp_pa(input logic [21:0] rpn, input logic [2:0] s,
                                         input logic [31:0] ea);
    logic [31:0] m;
    m = 32'hFFFF_FFFF << (10 + 2 * s);
    exp_pa = ({rpn, 10'h000} & m) | (ea & ~m);
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic special_purpose_register(input logic w, input logic p, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    priv <= p;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // software picks the slot; shadows flushed after every update
  task automatic tlb_put(input logic [5:0] i, input logic [21:0] tg, input logic [2:0] s,
                         input logic [7:0] id, input logic [21:0] r);
    @(posedge core_clk);
    tw <= 1'b1;
    tidx <= i;
    ttag <= tg;
    tsize <= s;
    tvalid <= 1'b1;
    ttid <= id;
    trpn <= r;
    @(posedge core_clk);
    tw <= 1'b0;
    inval <= 1'b1;
    @(posedge core_clk);
    inval <= 1'b0;
  endtask

  task automatic xlate(input logic ch, input logic [31:0] ea, input logic m,
                       input logic [31:0] pa);
    int n;
    @(posedge core_clk);
    if (ch) begin
      q_d.push_back({m, pa});
      go_d <= 1'b1;
      ea_d <= ea;
    end else begin
      q_f.push_back({m, pa});
      go_f <= 1'b1;
      ea_f <= ea;
    end
    @(posedge core_clk);
    go_f <= 1'b0;
    go_d <= 1'b0;
    for (n = 0; n < 40 && (ch ? !ddone : !fdone); n++) @(posedge core_clk);
    if (n == 40) begin
      num_errors++;
      complete_run();
    end
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    if (!rst && fdone) begin
      exp_f = q_f.size() ? q_f.pop_front() : 33'h1_DEAD_BEEF;
      `CHK("fetch", exp_f, {fmiss, fpa})
    end
    if (!rst && ddone) begin
      exp_d = q_d.size() ? q_d.pop_front() : 33'h1_DEAD_BEEF;
      `CHK("data", exp_d, {dmiss, dpa})
    end
    if (!rst && (ack || fault)) begin
      exp_s = q_s.size() ? q_s.pop_front() : 33'h1_DEAD_BEEF;
      `CHK("spr", exp_s, {fault, rdata})
    end
  end

  initial begin
    logic [31:0] ea;
    logic [21:0] r;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    seed = lfsr(seed);
    xlate(0, seed, 0, seed);
    seed = lfsr(seed);
    xlate(1, seed, 0, seed);
    q_s.push_back({1'b0, 32'h0000_0000});
    special_purpose_register(1, 1, 10'h3B1, {seed[31:8], 8'h5A});
    q_s.push_back({1'b0, 32'h0000_005A});
    special_purpose_register(0, 1, 10'h3B1, 0);
    q_s.push_back({1'b1, 32'h0000_005A});
    special_purpose_register(1, 0, 10'h3B1, 32'h0000_0011);
    q_s.push_back({1'b0, 32'h0000_005A});
    special_purpose_register(0, 1, 10'h3B1, 0);
    special_purpose_register(1, 1, 10'h3B0, 32'h0000_0022);
    special_purpose_register(0, 1, 10'h3B0, 0);
    ir <= 1'b1;
    dr <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      seed = lfsr(seed);
      ea = seed;
      seed = lfsr(seed);
      r = seed[21:0];
      tlb_put(6'(s * 8 + 1), ea[31:10], 3'(s), 8'h00, r);
      xlate(1, ea, 0, exp_pa(r, 3'(s), ea));
      xlate(0, ea, 0, exp_pa(r, 3'(s), ea));
      xlate(0, ea ^ 32'h0000_03FF, 0, exp_pa(r, 3'(s), ea ^ 32'h0000_03FF));
    end
    seed = lfsr(seed);
    ea = {~seed[31:24], seed[23:0]};
    tlb_put(62, ea[31:10], 1, 8'h33, 22'h15A5A5);
    xlate(0, ea, 1, 0);
    xlate(1, ea, 1, 0);
    q_s.push_back({1'b0, 32'h0000_005A});
    special_purpose_register(1, 1, 10'h3B1, 32'h0000_0033);
    xlate(0, ea, 0, exp_pa(22'h15A5A5, 1, ea));
    dr <= 1'b0;
    xlate(1, ea, 0, ea);
    ir <= 1'b0;
    xlate(0, ea, 0, ea);
    // every noted answer must have appeared
    `CHK("pending", 0, q_f.size() + q_d.size() + q_s.size())
    complete_run();
  end
endmodule

//--- verilog/vmt_shadow_buf.sv
`timescale 1ns/10ps
`include "vmt_regs.svh"

module vmt_shadow_buf #(
  parameter int DEPTH = `VMT_INSTRUCTION_SHADOW_BUFFER_ENTRIES
) (
  input wire logic     core_clk,
  input wire logic     rst,
  vmt_shadow_if.shb    sh
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("shadow depth must be a power of two, at least 2");
  end

  vmt_pkg::vmt_entry_t ent_ff  [DEPTH];
  vmt_pkg::vmt_entry_t nxt_ent [DEPTH];
  logic [IW-1:0]       ptr_ff;
  logic [IW-1:0]       nxt_ptr;

  // lookup needs no software help; filled only by hardware (R11)
  always_comb begin
    sh.hit = 1'b0;
    sh.pa  = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (vmt_pkg::vmt_hit(ent_ff[i], sh.ea[`VMT_ADDR_W-1:`VMT_OFS_W], sh.process_identifier_register)) begin
        sh.hit = 1'b1;
        sh.pa  = vmt_pkg::vmt_phys(ent_ff[i], sh.ea);
      end
    end
  end

  // round-robin victim: cheap, and a shadow miss adds no cycle while the unified port is free
  always_comb begin
    nxt_ent = ent_ff;
    nxt_ptr = ptr_ff;
    if (sh.inval) begin
      for (int i = 0; i < DEPTH; i++) begin
        nxt_ent[i].valid = 1'b0;
      end
    end else if (sh.fill_en) begin
      nxt_ent[ptr_ff] = sh.fill_ent; // R11
      nxt_ptr         = ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        ent_ff[i] <= '0;
      end
      ptr_ff <= '0;
    end else begin
      ent_ff <= nxt_ent;
      ptr_ff <= nxt_ptr;
    end
  end
endmodule

//--- verilog/vmt_translate.sv
`timescale 1ns/10ps
`include "vmt_regs.svh"

// What this block does
// (R1) Instruction fetches are translated only when the instruction relocate bit is 1.
// (R2) Loads and stores are translated only when the data relocate bit is 1, independently.
// (R3) Each address splits into a translated page number and an offset passed through unchanged.
// (R4) The virtual page number is the process identifier joined with the effective page number.
// (R5) The matching entry's page size sets the page-number and offset widths.
// (R6) Only entries held in the translation buffers are searched, never the software table.
// (R7) A hit joins the entry's physical page number with the offset into a 32-bit address.
// (R8) The process identifier register is 32 bits with the identifier in its low 8 bits.
// (R9) That register sits at special register address 945 and needs privilege to access.
// (R10) A 64-entry unified buffer holds both kinds of translation, written only by software.
// (R11) A 4-entry instruction and an 8-entry data shadow buffer are filled by hardware.
// (R12) Software looks translations up in its own table and picks which entry to replace.
// (R13) Each entry carries its own page size, 1 KB to 16 MB, freely mixed.
// (R14) After reset both translations are off and addresses pass through unchanged; this block follows the relocate bit inputs and does not reset them.
// (R15) Exactly eight page sizes exist, from 1 KB to 16 MB in steps of four.
// (R16) An entry tagged with process zero matches any process; others must match exactly.
// (R17) An enabled translation with no matching valid entry ends in a miss of its own type.
module vmt_translate #(
  parameter int UNIFIED_TRANSLATION_BUFFER_ENTRIES = `VMT_UNIFIED_TRANSLATION_BUFFER_ENTRIES,
  parameter int INSTRUCTION_SHADOW_BUFFER_ENTRIES = `VMT_INSTRUCTION_SHADOW_BUFFER_ENTRIES,
  parameter int DATA_SHADOW_BUFFER_ENTRIES = `VMT_DATA_SHADOW_BUFFER_ENTRIES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       instruction_relocate_bit,
  input  wire logic                       data_relocate_bit,
  input  wire logic                       spr_wr_en,
  input  wire logic                       spr_rd_en,
  input  wire logic                       spr_priv,
  input  wire logic [`VMT_SPR_ADDR_W-1:0] spr_addr,
  input  wire logic [31:0]                spr_wdata,
  output logic [31:0]                     spr_rdata,
  output logic                            spr_ack,
  output logic                            spr_fault,
  input  wire logic                       tlb_wr_en,
  input  wire logic [5:0]                 tlb_wr_index,
  input  wire logic [`VMT_EPN_W-1:0]      tlb_wr_tag,
  input  wire logic [`VMT_SIZE_W-1:0]     tlb_wr_size,
  input  wire logic                       tlb_wr_valid,
  input  wire logic [`VMT_PID_W-1:0]      tlb_wr_tid,
  input  wire logic [`VMT_EPN_W-1:0]      tlb_wr_rpn,
  input  wire logic                       shadow_inval,
  input  wire logic                       fetch_req,
  input  wire logic [`VMT_ADDR_W-1:0]     fetch_effective_address,
  output logic                            fetch_ready,
  output logic                            fetch_done,
  output logic                            fetch_miss,
  output logic [`VMT_ADDR_W-1:0]          fetch_pa,
  input  wire logic                       data_req,
  input  wire logic [`VMT_ADDR_W-1:0]     data_effective_address,
  output logic                            data_ready,
  output logic                            data_done,
  output logic                            data_miss,
  output logic [`VMT_ADDR_W-1:0]          data_pa
);
  localparam int UIW = $clog2(UNIFIED_TRANSLATION_BUFFER_ENTRIES);
  localparam int NCH = `VMT_CHANS;

  if (UNIFIED_TRANSLATION_BUFFER_ENTRIES != 64) begin : g_chk
    $error("unified buffer index port is 6 bits: 64 entries only");
  end

  // process identifier register
  logic [`VMT_PID_W-1:0] pid_ff;
  logic [`VMT_PID_W-1:0] nxt_pid;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic                  ack_ff;
  logic                  nxt_ack;
  logic                  fault_ff;
  logic                  nxt_fault;
  logic                  pid_sel;

  // unified buffer
  vmt_pkg::vmt_entry_t   unified_translation_buffer_ff  [UNIFIED_TRANSLATION_BUFFER_ENTRIES];
  vmt_pkg::vmt_entry_t   nxt_unified_translation_buffer [UNIFIED_TRANSLATION_BUFFER_ENTRIES];
  vmt_pkg::vmt_entry_t   wr_ent;
  vmt_pkg::vmt_entry_t   u_ent;
  logic                  u_hit;
  logic [`VMT_ADDR_W-1:0] u_pa;
  logic                  u_sel;

  // per-channel request state
  vmt_pkg::vmt_state_t   st_ff   [NCH];
  vmt_pkg::vmt_state_t   nxt_st  [NCH];
  logic [`VMT_ADDR_W-1:0] ea_ff  [NCH];
  logic [`VMT_ADDR_W-1:0] nxt_ea [NCH];
  logic [`VMT_ADDR_W-1:0] pa_ff  [NCH];
  logic [`VMT_ADDR_W-1:0] nxt_pa [NCH];
  logic [NCH-1:0]        xl_ff;
  logic [NCH-1:0]        nxt_xl;
  logic [NCH-1:0]        done_ff;
  logic [NCH-1:0]        nxt_done;
  logic [NCH-1:0]        miss_ff;
  logic [NCH-1:0]        nxt_miss;
  logic [NCH-1:0]        rdy_ff;
  logic [NCH-1:0]        nxt_rdy;
  logic [NCH-1:0]        gnt;
  logic [NCH-1:0]        sh_hit;
  logic [`VMT_ADDR_W-1:0] sh_pa  [NCH];
  logic [NCH-1:0]        req;
  logic [NCH-1:0]        reloc;
  logic [`VMT_ADDR_W-1:0] ea_in  [NCH];

  assign req   = {data_req, fetch_req};
  assign reloc = {data_relocate_bit, instruction_relocate_bit};
  assign ea_in[`VMT_CHAN_INSN] = fetch_effective_address;
  assign ea_in[`VMT_CHAN_DATA] = data_effective_address;

  // ---- special register access ----
  assign pid_sel = (spr_addr == `VMT_PID_SPR_ADDR); // R9

  always_comb begin
    nxt_pid   = pid_ff;
    nxt_rdata = rdata_ff;
    nxt_ack   = 1'b0;
    nxt_fault = 1'b0;
    if (pid_sel && (spr_wr_en || spr_rd_en)) begin
      if (!spr_priv) begin
        nxt_fault = 1'b1; // R9
      end else begin
        nxt_ack = 1'b1;
        if (spr_wr_en) begin
          nxt_pid = spr_wdata[`VMT_PID_LSB +: `VMT_PID_W]; // R8
        end
        if (spr_rd_en) begin
          // reserved upper bits read as zero
          nxt_rdata = {{(32 - `VMT_PID_W){1'b0}}, pid_ff}; // R8
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pid_ff   <= `VMT_PID_RST;
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      pid_ff   <= nxt_pid;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      fault_ff <= nxt_fault;
    end
  end

  // ---- unified buffer: software writes only ----
  always_comb begin
    wr_ent.tag   = tlb_wr_tag;
    wr_ent.size  = tlb_wr_size; // R13 R15
    wr_ent.valid = tlb_wr_valid;
    wr_ent.entry_process_tag   = tlb_wr_tid;
    wr_ent.rpn   = tlb_wr_rpn;
    nxt_unified_translation_buffer     = unified_translation_buffer_ff;
    if (tlb_wr_en) begin
      nxt_unified_translation_buffer[tlb_wr_index[UIW-1:0]] = wr_ent; // R10 R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < UNIFIED_TRANSLATION_BUFFER_ENTRIES; i++) begin
        unified_translation_buffer_ff[i] <= '0;
      end
    end else begin
      unified_translation_buffer_ff <= nxt_unified_translation_buffer;
    end
  end

  // one search port shared; instruction side wins a tie
  assign u_sel = !((st_ff[`VMT_CHAN_INSN] == vmt_pkg::VMT_LOOK) && xl_ff[`VMT_CHAN_INSN]
                   && !sh_hit[`VMT_CHAN_INSN]);

  always_comb begin
    u_hit = 1'b0;
    u_ent = '0;
    u_pa  = '0;
    for (int i = 0; i < UNIFIED_TRANSLATION_BUFFER_ENTRIES; i++) begin
      // process id joined with page number forms the virtual page number
      if (vmt_pkg::vmt_hit(unified_translation_buffer_ff[i], ea_ff[u_sel][`VMT_ADDR_W-1:`VMT_OFS_W],
                           pid_ff)) begin // R4 R6 R16
        u_hit = 1'b1;
        u_ent = unified_translation_buffer_ff[i];
        u_pa  = vmt_pkg::vmt_phys(unified_translation_buffer_ff[i], ea_ff[u_sel]); // R3 R5 R7
      end
    end
  end

  // ---- shadow buffers ----
  for (genvar g = 0; g < NCH; g++) begin : g_sh
    vmt_shadow_if shi ();

    assign shi.ea       = ea_ff[g];
    assign shi.process_identifier_register      = pid_ff; // R4
    assign shi.fill_en  = gnt[g] && u_hit; // R11
    assign shi.fill_ent = u_ent;
    assign shi.inval    = shadow_inval;
    assign sh_hit[g]    = shi.hit;
    assign sh_pa[g]     = shi.pa;

    vmt_shadow_buf #(
      .DEPTH (g == `VMT_CHAN_INSN ? INSTRUCTION_SHADOW_BUFFER_ENTRIES : DATA_SHADOW_BUFFER_ENTRIES)
    ) u_shb (
      .core_clk (core_clk),
      .rst      (rst),
      .sh       (shi)
    );
  end

  // ---- request sequencing per channel ----
  always_comb begin
    nxt_st   = st_ff;
    nxt_ea   = ea_ff;
    nxt_xl   = xl_ff;
    nxt_pa   = pa_ff;
    nxt_done = '0;
    nxt_miss = '0;
    gnt      = '0;
    for (int c = 0; c < NCH; c++) begin
      case (st_ff[c])
        vmt_pkg::VMT_IDLE: begin
          if (req[c]) begin
            nxt_st[c] = vmt_pkg::VMT_LOOK;
            nxt_ea[c] = ea_in[c];
            nxt_xl[c] = reloc[c]; // R1 R2
          end
        end
        vmt_pkg::VMT_LOOK: begin
          if (!xl_ff[c]) begin
            // real mode: effective address used as is
            nxt_pa[c]   = ea_ff[c]; // R1 R2 R14
            nxt_done[c] = 1'b1;
            nxt_st[c]   = vmt_pkg::VMT_IDLE;
          end else if (sh_hit[c]) begin
            nxt_pa[c]   = sh_pa[c]; // R7
            nxt_done[c] = 1'b1;
            nxt_st[c]   = vmt_pkg::VMT_IDLE;
          end else if (!tlb_wr_en && (u_sel == c[0])) begin
            // a software write owns the unified buffer this cycle
            gnt[c]      = 1'b1;
            nxt_done[c] = 1'b1;
            nxt_st[c]   = vmt_pkg::VMT_IDLE;
            if (u_hit) begin
              nxt_pa[c] = u_pa; // R7
            end else begin
              nxt_pa[c]   = '0;
              nxt_miss[c] = 1'b1; // R17
            end
          end
        end
        default: begin
          nxt_st[c] = vmt_pkg::VMT_IDLE;
        end
      endcase
      nxt_rdy[c] = (nxt_st[c] == vmt_pkg::VMT_IDLE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        st_ff[c] <= vmt_pkg::VMT_IDLE;
        ea_ff[c] <= '0;
        pa_ff[c] <= '0;
      end
      xl_ff   <= '0; // R14
      done_ff <= '0;
      miss_ff <= '0;
      rdy_ff  <= '1;
    end else begin
      st_ff   <= nxt_st;
      ea_ff   <= nxt_ea;
      pa_ff   <= nxt_pa;
      xl_ff   <= nxt_xl;
      done_ff <= nxt_done;
      miss_ff <= nxt_miss;
      rdy_ff  <= nxt_rdy;
    end
  end

  assign spr_rdata   = rdata_ff;
  assign spr_ack     = ack_ff;
  assign spr_fault   = fault_ff;
  assign fetch_ready = rdy_ff[`VMT_CHAN_INSN];
  assign fetch_done  = done_ff[`VMT_CHAN_INSN];
  assign fetch_miss  = miss_ff[`VMT_CHAN_INSN];
  assign fetch_pa    = pa_ff[`VMT_CHAN_INSN];
  assign data_ready  = rdy_ff[`VMT_CHAN_DATA];
  assign data_done   = done_ff[`VMT_CHAN_DATA];
  assign data_miss   = miss_ff[`VMT_CHAN_DATA];
  assign data_pa     = pa_ff[`VMT_CHAN_DATA];
endmodule
